// ### design/spm_defines.svh
// Constants for the setpoint manager: widths, scales and timing counts
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_DW 16
`define SPM_FULL_SCALE 16'hFFFF
`define SPM_ZERO 16'h0000
`define SPM_CLK_HZ 100000000
`define SPM_SAMPLE_HZ 1000
`define SPM_DISP_HZ 10
`define SPM_SAMPLE_CYC (`SPM_CLK_HZ / `SPM_SAMPLE_HZ)
`define SPM_DISP_DIV (`SPM_SAMPLE_HZ / `SPM_DISP_HZ)
`define SPM_SEC_DIV `SPM_SAMPLE_HZ
`define SPM_RED_PCT 128
`define SPM_PCT_BASE 100
`define SPM_CNT_W 24
`define SPM_DIV_W 10
`define SPM_SEC_W 16
`define SPM_NV_ADDR_W 1
`endif

// ### design/spm_limits.sv
// Setpoint limit register with ordered-pair check, clamp and range test
`include "spm_defines.svh"
`default_nettype none
module spm_limits
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lim_wr,
  input wire logic [`SPM_DW-1:0] lim_lo_in,
  input wire logic [`SPM_DW-1:0] lim_hi_in,
  input wire logic [`SPM_DW-1:0] test_val,
  output logic [`SPM_DW-1:0] lim_lo,
  output logic [`SPM_DW-1:0] lim_hi,
  output logic lim_rejected,
  output logic test_in_range,
  output logic [`SPM_DW-1:0] test_clamped
);
  logic lim_ok;
  assign lim_ok = (lim_lo_in <= lim_hi_in);
  assign test_in_range = (test_val >= lim_lo) && (test_val <= lim_hi);
  assign test_clamped = (test_val < lim_lo) ? lim_lo : (test_val > lim_hi) ? lim_hi : test_val;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_lo <= `SPM_ZERO;
      lim_hi <= `SPM_FULL_SCALE;
      lim_rejected <= 1'b0;
    end else begin
      lim_rejected <= lim_wr && !lim_ok;
      if (lim_wr && lim_ok) begin
        lim_lo <= lim_lo_in;
        lim_hi <= lim_hi_in;
      end
    end
  end
endmodule : spm_limits
`default_nettype wire

// ### design/spm_pkg.sv
// Types shared by the setpoint manager modules
`default_nettype none
package spm_pkg;
  typedef enum logic [1:0] {
    SPM_SRC_SERIAL_PANEL,
    SPM_SRC_ANALOG,
    SPM_SRC_RSVD2,
    SPM_SRC_RSVD3
  } spm_src_t;
  typedef enum logic [1:0] {
    SPM_ST_BOOT,
    SPM_ST_RUN,
    SPM_ST_TARE_WAIT
  } spm_state_t;
endpackage : spm_pkg
`default_nettype wire

// ### design/spm_setpoint_manager.sv
// Setpoint manager: source selection, limits, power-up, ramp, tare and display pacing
// Functional notes
// - Sample pressure 1000 per second, refresh display 10 per second.
// - Serial/panel mode: newest command from either source wins.
// - Analog mode: drop serial setpoints, block panel entry.
// - Out-of-limit serial setpoint not applied; answered with error.
// - Out-of-limit analog setpoint clamped to nearest limit.
// - Limits default to full measuring range; tighter limits configurable.
// - Limits held as fractions of full scale, independent of variable.
// - Autotare after configurable seconds of zero setpoint when enabled.
// - Modbus idle timeout forces zero or keeps setpoint; default never.
// - Power-up setpoint: last stored value, or configured fixed value.
// - Power-up ramp starts from zero; ramp or jump as configured.
// - Zero setpoint honours ramp or snaps to zero, as configured.
// - Tare captures pressure as zero; readings reported relative.
// - Display red above 128% of range, white otherwise; pressure_rel never exceeds full scale, so disp_red stays low.
// - Clear then set on entry screen cancels the setpoint.
// - Knob setpoints apply only in analog source mode.
// - Report converter error, exhaust, panel lock, over range, hold.
`include "spm_defines.svh"
`default_nettype none
module spm_setpoint_manager
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] src_sel,
  input wire logic serial_sp_valid,
  input wire logic [`SPM_DW-1:0] serial_sp_data,
  input wire logic panel_sp_valid,
  input wire logic [`SPM_DW-1:0] panel_sp_data,
  input wire logic panel_clear,
  input wire logic panel_set,
  input wire logic [`SPM_DW-1:0] analog_sp_in,
  input wire logic knob_present,
  input wire logic [`SPM_DW-1:0] potentiometer_knob_input,
  input wire logic lim_wr,
  input wire logic [`SPM_DW-1:0] lim_lo_in,
  input wire logic [`SPM_DW-1:0] lim_hi_in,
  input wire logic autotare_en,
  input wire logic [`SPM_SEC_W-1:0] tare_delay_sec,
  input wire logic tare_req,
  input wire logic modbus_activity,
  input wire logic modbus_timeout_en,
  input wire logic [`SPM_SEC_W-1:0] modbus_timeout_sec,
  input wire logic modbus_timeout_zero,
  input wire logic pu_fixed_en,
  input wire logic [`SPM_DW-1:0] pu_fixed_sp,
  input wire logic [`SPM_DW-1:0] nv_sp_in,
  input wire logic pu_ramp_en,
  input wire logic zero_ramp_en,
  input wire logic [`SPM_DW-1:0] ramp_step,
  input wire logic [`SPM_DW-1:0] pressure_raw,
  input wire logic adc_error,
  input wire logic exhaust_mode,
  input wire logic panel_lock,
  input wire logic valve_hold,
  output logic [`SPM_DW-1:0] setpoint_target,
  output logic [`SPM_DW-1:0] setpoint_active,
  output logic serial_sp_ack,
  output logic serial_sp_err,
  output logic panel_blocked,
  output logic lim_rejected,
  output logic [`SPM_DW-1:0] lim_lo_frac,
  output logic [`SPM_DW-1:0] lim_hi_frac,
  output logic nv_wr,
  output logic [`SPM_DW-1:0] nv_wr_data,
  output logic tare_pulse,
  output logic [`SPM_DW-1:0] tare_ref,
  output logic [`SPM_DW-1:0] pressure_rel,
  output logic [`SPM_DW-1:0] disp_value,
  output logic disp_update,
  output logic disp_red,
  output logic converter_err_flag,
  output logic exhaust_active_flag,
  output logic panel_locked_flag,
  output logic over_range_flag,
  output logic valve_hold_flag
);
  spm_tick_if ticks ();
  spm_state_t state_reg;
  spm_state_t state_next;
  logic analog_mode;
  logic [`SPM_DW-1:0] lim_test;
  logic [`SPM_DW-1:0] lim_lo_w;
  logic [`SPM_DW-1:0] lim_hi_w;
  logic lim_rej_w;
  logic ser_in_range;
  logic [`SPM_DW-1:0] analog_clamped;
  logic [`SPM_DW-1:0] analog_src;
  logic clear_armed_reg;
  logic cancel_cmd;
  logic ser_apply;
  logic pan_apply;
  logic [`SPM_DW-1:0] idle_reg;
  logic idle_expired;
  logic [`SPM_DW-1:0] zero_cnt_reg;
  logic tare_due;
  logic ramp_on;
  logic snap_zero_reg;
  logic ramping_up;
  logic [`SPM_DW:0] ramp_sum;
  logic [`SPM_DW:0] ramp_diff;
  logic [`SPM_DW-1:0] ramp_val;
  logic [`SPM_DW-1:0] press_samp_reg;
  logic [`SPM_DW+7:0] red_lhs;
  logic [`SPM_DW+7:0] red_rhs;
  logic [`SPM_DW-1:0] target_next;

  spm_timebase u_timebase (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ticks(ticks.src)
  );

  spm_limits u_limits (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lim_wr(lim_wr),
    .lim_lo_in(lim_lo_in),
    .lim_hi_in(lim_hi_in),
    .test_val(lim_test),
    .lim_lo(lim_lo_w),
    .lim_hi(lim_hi_w),
    .lim_rejected(lim_rej_w),
    .test_in_range(),
    .test_clamped(analog_clamped)
  );

  assign analog_mode = (spm_src_t'(src_sel) == SPM_SRC_ANALOG);
  assign analog_src = knob_present ? potentiometer_knob_input : analog_sp_in;
  assign lim_test = analog_src;
  assign ser_in_range = (serial_sp_data >= lim_lo_w) && (serial_sp_data <= lim_hi_w);
  assign ser_apply = serial_sp_valid && !analog_mode && ser_in_range;
  assign pan_apply = panel_sp_valid && !analog_mode;
  assign cancel_cmd = panel_set && clear_armed_reg && !analog_mode;
  assign idle_expired = modbus_timeout_en && (modbus_timeout_sec != '0)
    && (idle_reg >= modbus_timeout_sec) && ticks.sec_tick;
  assign tare_due = autotare_en && (setpoint_target == `SPM_ZERO)
    && (zero_cnt_reg == tare_delay_sec) && ticks.sec_tick;
  assign ramp_on = !snap_zero_reg && (ramp_step != '0);
  assign ramping_up = setpoint_active < setpoint_target;
  assign ramp_sum = {1'b0, setpoint_active} + {1'b0, ramp_step};
  assign ramp_diff = {1'b0, setpoint_active} - {1'b0, ramp_step};
  assign ramp_val = ramping_up
    ? ((ramp_sum[`SPM_DW] || ramp_sum[`SPM_DW-1:0] > setpoint_target)
       ? setpoint_target : ramp_sum[`SPM_DW-1:0])
    : ((ramp_diff[`SPM_DW] || ramp_diff[`SPM_DW-1:0] < setpoint_target)
       ? setpoint_target : ramp_diff[`SPM_DW-1:0]);
  assign red_lhs = {8'h00, pressure_rel} * (`SPM_DW+8)'(`SPM_PCT_BASE);
  assign red_rhs = {8'h00, `SPM_FULL_SCALE} * (`SPM_DW+8)'(`SPM_RED_PCT);

  always_comb begin
    target_next = setpoint_target;
    state_next = state_reg;
    case (state_reg)
      SPM_ST_BOOT: begin
        target_next = pu_fixed_en ? pu_fixed_sp : nv_sp_in;
        state_next = SPM_ST_RUN;
      end
      SPM_ST_RUN, SPM_ST_TARE_WAIT: begin
        if (analog_mode) begin
          target_next = analog_clamped;
        end else if (cancel_cmd) begin
          target_next = `SPM_ZERO;
        end else if (pan_apply) begin
          target_next = panel_sp_data;
        end else if (ser_apply) begin
          target_next = serial_sp_data;
        end else if (idle_expired && modbus_timeout_zero) begin
          target_next = `SPM_ZERO;
        end
        state_next = (autotare_en && target_next == `SPM_ZERO) ? SPM_ST_TARE_WAIT : SPM_ST_RUN;
      end
      default: begin
        state_next = SPM_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPM_ST_BOOT;
      setpoint_target <= `SPM_ZERO;
      clear_armed_reg <= 1'b0;
      snap_zero_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      setpoint_target <= target_next;
      if (panel_clear) begin
        clear_armed_reg <= 1'b1;
      end else if (panel_set || panel_sp_valid) begin
        clear_armed_reg <= 1'b0;
      end
      if (state_reg == SPM_ST_BOOT) begin
        snap_zero_reg <= !pu_ramp_en;
      end else if (target_next != setpoint_target) begin
        snap_zero_reg <= (target_next == `SPM_ZERO) && !zero_ramp_en;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_active <= `SPM_ZERO;
    end else if (state_reg != SPM_ST_BOOT) begin
      if (!ramp_on) begin
        setpoint_active <= setpoint_target;
      end else if (ticks.sample_tick) begin
        setpoint_active <= ramp_val;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_sp_ack <= 1'b0;
      serial_sp_err <= 1'b0;
      panel_blocked <= 1'b0;
      nv_wr <= 1'b0;
      nv_wr_data <= `SPM_ZERO;
    end else begin
      serial_sp_ack <= ser_apply;
      serial_sp_err <= serial_sp_valid && !analog_mode && !ser_in_range;
      panel_blocked <= analog_mode;
      nv_wr <= !pu_fixed_en && (state_reg != SPM_ST_BOOT) && (target_next != setpoint_target);
      nv_wr_data <= target_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= '0;
      zero_cnt_reg <= '0;
    end else begin
      if (modbus_activity || idle_expired) begin
        idle_reg <= '0;
      end else if (ticks.sec_tick && idle_reg != '1) begin
        idle_reg <= idle_reg + 1'b1;
      end
      if (state_reg != SPM_ST_TARE_WAIT || tare_due) begin
        zero_cnt_reg <= '0;
      end else if (ticks.sec_tick && zero_cnt_reg != '1) begin
        zero_cnt_reg <= zero_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tare_ref <= `SPM_ZERO;
      tare_pulse <= 1'b0;
      press_samp_reg <= `SPM_ZERO;
      pressure_rel <= `SPM_ZERO;
    end else begin
      tare_pulse <= tare_req || tare_due;
      if (tare_req || tare_due) begin
        tare_ref <= press_samp_reg;
      end
      if (ticks.sample_tick) begin
        press_samp_reg <= pressure_raw;
        pressure_rel <= (pressure_raw > tare_ref) ? pressure_raw - tare_ref : `SPM_ZERO;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_update <= 1'b0;
      disp_value <= `SPM_ZERO;
      disp_red <= 1'b0;
    end else begin
      disp_update <= ticks.disp_tick;
      if (ticks.disp_tick) begin
        disp_value <= pressure_rel;
        disp_red <= red_lhs > red_rhs;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_err_flag <= 1'b0;
      exhaust_active_flag <= 1'b0;
      panel_locked_flag <= 1'b0;
      over_range_flag <= 1'b0;
      valve_hold_flag <= 1'b0;
      lim_rejected <= 1'b0;
      lim_lo_frac <= `SPM_ZERO;
      lim_hi_frac <= `SPM_FULL_SCALE;
    end else begin
      converter_err_flag <= adc_error;
      exhaust_active_flag <= exhaust_mode;
      panel_locked_flag <= panel_lock;
      over_range_flag <= press_samp_reg == `SPM_FULL_SCALE;
      valve_hold_flag <= valve_hold;
      lim_rejected <= lim_rej_w;
      lim_lo_frac <= lim_lo_w;
      lim_hi_frac <= lim_hi_w;
    end
  end
endmodule : spm_setpoint_manager
`default_nettype wire

// ### design/spm_tick_if.sv
// Pacing ticks passed from the timebase to the setpoint manager core
`default_nettype none
interface spm_tick_if;
  logic sample_tick;
  logic disp_tick;
  logic sec_tick;
  modport src (output sample_tick, output disp_tick, output sec_tick);
  modport dst (input sample_tick, input disp_tick, input sec_tick);
endinterface : spm_tick_if
`default_nettype wire

// ### design/spm_timebase.sv
// Sample, display and one-second tick generator
`include "spm_defines.svh"
`default_nettype none
module spm_timebase
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  spm_tick_if.src ticks
);
  logic [`SPM_CNT_W-1:0] cyc_reg;
  logic [`SPM_DIV_W-1:0] disp_reg;
  logic [`SPM_DIV_W-1:0] sec_reg;
  logic samp_next;
  logic disp_wrap;
  logic sec_wrap;
  assign samp_next = (cyc_reg == `SPM_CNT_W'(`SPM_SAMPLE_CYC - 1));
  assign disp_wrap = (disp_reg == `SPM_DIV_W'(`SPM_DISP_DIV - 1));
  assign sec_wrap = (sec_reg == `SPM_DIV_W'(`SPM_SEC_DIV - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= '0;
      disp_reg <= '0;
      sec_reg <= '0;
      ticks.sample_tick <= 1'b0;
      ticks.disp_tick <= 1'b0;
      ticks.sec_tick <= 1'b0;
    end else begin
      cyc_reg <= samp_next ? '0 : cyc_reg + 1'b1;
      ticks.sample_tick <= samp_next;
      ticks.disp_tick <= samp_next && disp_wrap;
      ticks.sec_tick <= samp_next && sec_wrap;
      if (samp_next) begin
        disp_reg <= disp_wrap ? '0 : disp_reg + 1'b1;
        sec_reg <= sec_wrap ? '0 : sec_reg + 1'b1;
      end
    end
  end
endmodule : spm_timebase
`default_nettype wire

// ### verif/spm_checker.sv
// Port-level assertion checker for the setpoint manager
`include "spm_defines.svh"
`default_nettype none
module spm_checker
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] src_sel,
  input wire logic serial_sp_valid,
  input wire logic [`SPM_DW-1:0] serial_sp_data,
  input wire logic panel_sp_valid,
  input wire logic [`SPM_DW-1:0] panel_sp_data,
  input wire logic panel_set,
  input wire logic [`SPM_DW-1:0] analog_sp_in,
  input wire logic knob_present,
  input wire logic [`SPM_DW-1:0] potentiometer_knob_input,
  input wire logic lim_wr,
  input wire logic [`SPM_DW-1:0] lim_lo_in,
  input wire logic [`SPM_DW-1:0] lim_hi_in,
  input wire logic adc_error,
  input wire logic exhaust_mode,
  input wire logic panel_lock,
  input wire logic valve_hold,
  input wire logic [`SPM_DW-1:0] setpoint_target,
  input wire logic serial_sp_ack,
  input wire logic serial_sp_err,
  input wire logic panel_blocked,
  input wire logic lim_rejected,
  input wire logic [`SPM_DW-1:0] lim_lo_frac,
  input wire logic [`SPM_DW-1:0] lim_hi_frac,
  input wire logic disp_red,
  input wire logic converter_err_flag,
  input wire logic exhaust_active_flag,
  input wire logic panel_locked_flag,
  input wire logic valve_hold_flag
);
  logic run_reg;
  logic lim_d_reg;
  logic quiet;
  logic ser_ok;
  logic [`SPM_DW-1:0] ana_sel;
  logic [`SPM_DW-1:0] ana_exp;
  // Skips the boot edge and the cycles where limit outputs still lag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      lim_d_reg <= 1'b0;
    end else begin
      run_reg <= 1'b1;
      lim_d_reg <= lim_wr;
    end
  end
  assign quiet = run_reg && !lim_wr && !lim_d_reg && !panel_sp_valid && !panel_set;
  assign ser_ok = serial_sp_data >= lim_lo_frac && serial_sp_data <= lim_hi_frac;
  assign ana_sel = knob_present ? potentiometer_knob_input : analog_sp_in;
  assign ana_exp = (ana_sel > lim_hi_frac) ? lim_hi_frac :
                   ((ana_sel < lim_lo_frac) ? lim_lo_frac : ana_sel);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_SER_TAKE: assert property (
    quiet && serial_sp_valid && src_sel != 2'h1 && ser_ok
    |=> serial_sp_ack && !serial_sp_err && setpoint_target == $past(serial_sp_data))
    else $error("in-range serial setpoint not applied");
  AST_SER_ERR: assert property (
    quiet && serial_sp_valid && src_sel != 2'h1 && !ser_ok
    |=> serial_sp_err && !serial_sp_ack && $stable(setpoint_target))
    else $error("out-of-range serial setpoint not refused");
  AST_ANA_DROP: assert property (
    serial_sp_valid && src_sel == 2'h1 |=> !serial_sp_ack && !serial_sp_err)
    else $error("serial setpoint answered in analog mode");
  AST_BLOCK: assert property (
    1'b1 |=> panel_blocked == ($past(src_sel) == 2'h1))
    else $error("panel block does not follow source");
  AST_ANA_TARGET: assert property (
    quiet && src_sel == 2'h1 |=> setpoint_target == $past(ana_exp))
    else $error("analog setpoint not clamped to limits");
  AST_PANEL_TAKE: assert property (
    run_reg && panel_sp_valid && src_sel != 2'h1 && !panel_set
    |=> setpoint_target == $past(panel_sp_data))
    else $error("newest panel setpoint not applied");
  AST_LIM_BAD: assert property (
    lim_wr && lim_lo_in > lim_hi_in
    |=> ##1 (lim_rejected && $stable(lim_lo_frac) && $stable(lim_hi_frac)))
    else $error("inverted limit pair not refused");
  AST_LIM_OK: assert property (
    lim_wr && lim_lo_in <= lim_hi_in
    |=> ##1 (!lim_rejected && lim_lo_frac == $past(lim_lo_in, 2)
    && lim_hi_frac == $past(lim_hi_in, 2)))
    else $error("valid limit pair not taken");
  AST_FLAGS: assert property (
    1'b1 |=> {converter_err_flag, exhaust_active_flag, panel_locked_flag, valve_hold_flag}
    == $past({adc_error, exhaust_mode, panel_lock, valve_hold}))
    else $error("status flags do not follow their causes");
  AST_NO_RED: assert property (!disp_red)
    else $error("red shown while within 16-bit range");
endmodule : spm_checker
bind spm_setpoint_manager spm_checker i_chk (.*);
`default_nettype wire

// ### verif/spm_host_model.sv
// Serial host model issuing setpoint requests
`default_nettype none
module spm_host_model (
  input wire logic sys_clk,
  output logic serial_sp_valid,
  output logic [15:0] serial_sp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_sp_valid = 1'b0;
    serial_sp_data = 16'h5A5A;
  end
  // Holds the request over one edge; leaves valid up for back-to-back use
  task automatic send(input logic [15:0] val);
    serial_sp_valid = 1'b1;
    serial_sp_data = val;
    @(posedge sys_clk);
    #1;
  endtask : send
  // Released data line shows the inverse of the last value
  task automatic idle;
    serial_sp_valid = 1'b0;
    serial_sp_data = ~serial_sp_data;
  endtask : idle
endmodule : spm_host_model
`default_nettype wire

// ### verif/spm_setpoint_manager_bench.sv
// Self-checking testbench for the setpoint manager
`include "spm_defines.svh"
`default_nettype none
module spm_setpoint_manager_bench
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, serial_sp_valid, panel_sp_valid, panel_clear, panel_set, knob_present;
  logic lim_wr, autotare_en, tare_req, modbus_activity, modbus_timeout_en, modbus_timeout_zero;
  logic pu_fixed_en, pu_ramp_en, zero_ramp_en, adc_error, exhaust_mode, panel_lock, valve_hold;
  logic [1:0] src_sel;
  logic [`SPM_DW-1:0] serial_sp_data, panel_sp_data, analog_sp_in, potentiometer_knob_input;
  logic [`SPM_DW-1:0] lim_lo_in, lim_hi_in, pu_fixed_sp, nv_sp_in, ramp_step, pressure_raw;
  logic [`SPM_SEC_W-1:0] tare_delay_sec, modbus_timeout_sec;
  logic [`SPM_DW-1:0] setpoint_target, setpoint_active, lim_lo_frac, lim_hi_frac, nv_wr_data;
  logic [`SPM_DW-1:0] tare_ref, pressure_rel, disp_value, lo, hi, tgt;
  logic serial_sp_ack, serial_sp_err, panel_blocked, lim_rejected, nv_wr, tare_pulse;
  logic disp_update, disp_red, converter_err_flag, exhaust_active_flag, panel_locked_flag;
  logic over_range_flag, valve_hold_flag;
  logic [3:0] st;
  logic [16:0] exp_q[$];
  int failures, num_checks, seed;
  spm_setpoint_manager i_dut (.*);
  spm_host_model i_host (.sys_clk(sys_clk), .serial_sp_valid(serial_sp_valid),
    .serial_sp_data(serial_sp_data));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic ser(input logic [15:0] val);
    if (val >= lo && val <= hi) tgt = val;
    exp_q.push_back({val < lo || val > hi, tgt});
    i_host.send(val);
  endtask : ser
  task automatic lim(input logic [15:0] l, input logic [15:0] h);
    lim_lo_in = l;
    lim_hi_in = h;
    lim_wr = 1'b1;
    tick(1);
    lim_wr = 1'b0;
    if (l <= h) begin
      lo = l;
      hi = h;
    end
    // Refusal pulse and fraction outputs stand one edge after the limit register
    tick(1);
    chk({16'h0, lim_rejected}, {16'h0, l > h});
    chk({1'b0, lim_lo_frac}, {1'b0, lo});
    chk({1'b0, lim_hi_frac}, {1'b0, hi});
    tick(1);
  endtask : lim
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    lo = 16'h0;
    hi = 16'hFFFF;
    tick(2);
  endtask : do_reset
  // Each answer pulse takes the oldest expected note
  always @(negedge sys_clk) begin
    if (serial_sp_ack === 1'b1 || serial_sp_err === 1'b1) begin
      if (exp_q.size() == 0) chk({serial_sp_err, setpoint_target}, 17'h1FFFF);
      else chk({serial_sp_err, setpoint_target}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
  initial begin
    seed = 32'h1501;
    {panel_sp_valid, panel_clear, panel_set, knob_present, lim_wr, tare_req} = '0;
    {adc_error, exhaust_mode, panel_lock, valve_hold, modbus_activity, src_sel, pu_fixed_en} = '0;
    {autotare_en, modbus_timeout_en, modbus_timeout_zero, pu_ramp_en, zero_ramp_en} = 5'h1F;
    {panel_sp_data, analog_sp_in, potentiometer_knob_input, lim_lo_in, lim_hi_in} = '0;
    {ramp_step, pressure_raw, modbus_timeout_sec, tare_delay_sec} = {48'h0, 16'h3};
    pu_fixed_sp = 16'h2468;
    nv_sp_in = 16'h1357;
    do_reset();
    chk({1'b0, lim_lo_frac}, 17'h0);
    chk({1'b0, lim_hi_frac}, 17'h0FFFF);
    chk({1'b0, setpoint_target}, {1'b0, nv_sp_in});
    chk({1'b0, setpoint_active}, {1'b0, nv_sp_in});
    ser(16'h4000);
    i_host.idle();
    chk({16'h0, nv_wr}, 17'h1);
    chk({1'b0, nv_wr_data}, 17'h04000);
    tick(1);
    // Fixed power-up value for frequent host updates
    pu_fixed_en = 1'b1;
    do_reset();
    tgt = pu_fixed_sp;
    chk({1'b0, setpoint_target}, {1'b0, tgt});
    repeat (8) ser(16'($random(seed)));
    i_host.idle();
    lim(16'h1000, 16'h8000);
    lim(16'h9000, 16'h2000);
    repeat (12) ser(16'($random(seed)));
    ser(16'h8001);
    ser(16'h0FFF);
    ser(16'h3000);
    i_host.idle();
    panel_sp_valid = 1'b1;
    panel_sp_data = 16'h0123;
    tick(1);
    panel_sp_valid = 1'b0;
    panel_clear = 1'b1;
    tick(1);
    panel_clear = 1'b0;
    tick(2);
    chk({1'b0, setpoint_target}, 17'h00123);
    panel_set = 1'b1;
    tick(1);
    panel_set = 1'b0;
    tick(1);
    chk({1'b0, setpoint_target}, 17'h0);
    chk({1'b0, setpoint_active}, 17'h0);
    src_sel = 2'h1;
    analog_sp_in = 16'hF000;
    tick(2);
    chk({1'b0, setpoint_target}, {1'b0, hi});
    chk({16'h0, panel_blocked}, 17'h1);
    analog_sp_in = 16'h0010;
    tick(2);
    chk({1'b0, setpoint_target}, {1'b0, lo});
    knob_present = 1'b1;
    potentiometer_knob_input = 16'h4321;
    tick(2);
    chk({1'b0, setpoint_target}, 17'h04321);
    i_host.send(16'h2000);
    i_host.idle();
    panel_sp_valid = 1'b1;
    tick(1);
    panel_sp_valid = 1'b0;
    tick(2);
    chk({1'b0, setpoint_target}, 17'h04321);
    repeat (8) begin
      st = 4'($random(seed));
      {adc_error, exhaust_mode, panel_lock, valve_hold} = st;
      pressure_raw = 16'($random(seed));
      modbus_activity = st[0];
      tick(2);
      chk({13'h0, converter_err_flag, exhaust_active_flag, panel_locked_flag,
        valve_hold_flag}, {13'h0, st});
      // No sample or display tick falls inside this run
      chk({15'h0, over_range_flag, disp_update}, 17'h0);
    end
    tare_req = 1'b1;
    tick(1);
    tare_req = 1'b0;
    chk({16'h0, tare_pulse}, 17'h1);
    chk({1'b0, tare_ref}, 17'h0);
    chk(17'(exp_q.size()), 17'h0);
    wrap_up();
  end
endmodule : spm_setpoint_manager_bench
`default_nettype wire
